// [hw/arx_cmd_port.sv]
// Notes on behaviour
// - Instruction is eight bits, MSB first, taken on first eight rising SCK edges.
// - Write data MSB follows instruction directly, latched on next rising edge.
// - Write data length: 16 config, 32 transmit, 128 label memory.
// - Read data MSB driven at first falling edge after last instruction bit.
// - Upper nibble is channel 1 to 8, lower nibble is operation.
// - Op codes 0x0 and 0xA-0xF do nothing and carry no data.
// - 0x1 writes sixteen labels, 128 bits; 0x2 reads them back.
// - 0x3 returns next received word of channel, zeros when empty.
// - 0x4 loads channel config and clears its FIFO; 0x5 reads it.
// - 0x7 and hardware reset pin clear FIFOs, keep configuration.
// - 0x8 and 0x9 load transmit word at high or low rate.
// - Config bit 0 selects reference divided by 10 or by 80.
// - Config bit 1 picks not-empty or full indicator; combined output ORs all.
// - Config bit 2 enables label recognition for the channel.
// - Config bit 3 clears channel and keeps it disabled while high.
// - Config bit 4 enables odd parity checking of received words.
// - Config bit 5 low feeds receiver from transmit word for self-test.
// - Decoder enabled: word bits 10 and 9 must match config bits 7, 8.
// - Config bit 9 selects reversed or as-received label order on read.
// - Config bits 10 to 15 unused and read as zero.
// - One status register read by 0x6; bit 0 low while receiver 1 has data.
// - Status bits 0-7 show empty, bits 8-15 show full, per receiver.
`timescale 1ns/1ps
`include "arx_consts.svh"
module arx_cmd_port (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        cs_n,
    input  wire logic        sck,
    input  wire logic        si,
    output logic             so,
    input  wire logic        hardware_reset_pin,
    input  wire logic        rx_valid,
    output logic             rx_ready,
    input  wire logic [2:0]  rx_chan,
    input  wire logic [31:0] rx_word,
    output logic [7:0]       per_channel_indicator,
    output logic             indicator_any,
    output logic [7:0]       rate_select_bit,
    output logic [7:0]       loopback_select,
    output logic [7:0]       receiver_clear,
    output logic [31:0]      tx_word,
    output logic             tx_low_speed,
    output logic             tx_load
);
    arx_pkg::arx_state_t state_r;
    logic [7:0]   instr_r;
    logic [7:0]   cnt_r;
    logic [7:0]   len_r;
    logic [127:0] shreg_r;
    logic         so_r;
    logic [3:0]   tgt_op_r;
    logic [2:0]   tgt_ch_r;
    logic         tgt_ok_r;
    logic         sck_prev_r;
    logic         sck_rise;
    logic         sck_fall;
    logic [7:0]   instr_full;
    logic [3:0]   dec_op;
    logic [3:0]   dec_nib;
    logic [2:0]   dec_ch;
    logic         dec_ch_ok;
    logic         decode;
    logic         commit;
    logic [127:0] wr_data;
    logic [127:0] rd_data;
    logic         master_clr;
    logic         pop_strobe;
    logic [15:0]  cfg_r   [8];
    logic [127:0] label_r [8];
    logic [7:0]   cfg_wr;
    logic [7:0]   fifo_empty;
    logic [7:0]   fifo_full;
    logic [31:0]  head_word [8];
    logic [15:0]  status;
    logic         ing_valid;
    logic         ing_ready;
    logic [34:0]  ing_data;
    logic [2:0]   ing_ch;
    logic [31:0]  ing_word;
    logic [31:0]  ing_store;
    logic         ing_accept;

    // Reverse the eight label bits for the reversed read order
    function automatic logic [31:0] arx_order(input logic [31:0] w, input logic as_received);
        logic [7:0] rev;
        rev = '0;
        for (int k = 0; k < 8; k++) begin
            rev[k] = w[7-k];
        end
        return as_received ? w : {w[31:8], rev};
    endfunction : arx_order

    // Label lookup over all sixteen entries of a channel's table
    function automatic logic arx_label_hit(input logic [127:0] tbl, input logic [7:0] lbl);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < 16; k++) begin
            hit = hit | (tbl[k*8 +: 8] == lbl);
        end
        return hit;
    endfunction : arx_label_hit

    // Pins are synchronous, so a one-cycle history is enough for edge detection
    assign sck_rise = ce & ~cs_n & sck & ~sck_prev_r;
    assign sck_fall = ce & ~cs_n & ~sck & sck_prev_r;

    // Instruction decode, valid on the eighth rising edge
    assign instr_full = {instr_r[6:0], si};
    assign dec_op     = instr_full[3:0];
    assign dec_nib    = instr_full[7:4];
    assign dec_ch     = 3'(dec_nib - 4'h1);
    assign dec_ch_ok  = (dec_nib >= `ARX_CHAN_FIRST) && (dec_nib <= `ARX_CHAN_LAST);
    assign decode     = sck_rise && (state_r == arx_pkg::ARX_ST_INSTR) && (cnt_r == `ARX_INSTR_BITS - 8'h01);
    assign wr_data    = {shreg_r[126:0], si};
    assign commit     = sck_rise && (state_r == arx_pkg::ARX_ST_WRITE) && (cnt_r == len_r - 8'h01);
    assign master_clr = (decode && (dec_op == `ARX_OP_MASTER_RST)) | (ce & hardware_reset_pin);
    assign pop_strobe = decode && (dec_op == `ARX_OP_FIFO_RD) && dec_ch_ok;

    // Read data, left aligned so the MSB sits at the top of the shifter
    always_comb begin
        rd_data = '0;
        unique case (dec_op)
            `ARX_OP_LABEL_RD: rd_data = dec_ch_ok ? label_r[dec_ch] : '0;
            `ARX_OP_FIFO_RD: begin
                if (dec_ch_ok && !fifo_empty[dec_ch]) begin
                    rd_data = {arx_order(head_word[dec_ch], cfg_r[dec_ch][`ARX_CFG_LBL_ORDER]), 96'h0};
                end
            end
            `ARX_OP_CFG_RD: rd_data = dec_ch_ok ? {cfg_r[dec_ch] & `ARX_CFG_USED_MASK, 112'h0} : '0;
            `ARX_OP_STATUS_RD: rd_data = {status, 112'h0};
            default: rd_data = '0;
        endcase
    end

    // Serial sequencer: instruction, then write or read field, then idle until deselect
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r    <= arx_pkg::ARX_ST_INSTR;
            instr_r    <= 8'h00;
            cnt_r      <= 8'h00;
            len_r      <= 8'h00;
            shreg_r    <= '0;
            so_r       <= 1'b0;
            tgt_op_r   <= 4'h0;
            tgt_ch_r   <= 3'h0;
            tgt_ok_r   <= 1'b0;
            sck_prev_r <= 1'b0;
        end else if (ce) begin
            sck_prev_r <= sck;
            if (cs_n) begin
                state_r <= arx_pkg::ARX_ST_INSTR;
                cnt_r   <= 8'h00;
                so_r    <= 1'b0;
            end else begin
                unique case (state_r)
                    arx_pkg::ARX_ST_INSTR: begin
                        if (sck_rise) begin
                            instr_r <= instr_full;
                            cnt_r   <= cnt_r + 8'h01;
                        end
                        if (decode) begin
                            cnt_r    <= 8'h00;
                            tgt_op_r <= dec_op;
                            tgt_ch_r <= dec_ch;
                            tgt_ok_r <= dec_ch_ok;
                            shreg_r  <= rd_data;
                            unique case (dec_op)
                                `ARX_OP_LABEL_WR: begin
                                    state_r <= arx_pkg::ARX_ST_WRITE;
                                    len_r   <= `ARX_LEN_LABEL;
                                end
                                `ARX_OP_CFG_WR: begin
                                    state_r <= arx_pkg::ARX_ST_WRITE;
                                    len_r   <= `ARX_LEN_CFG;
                                end
                                `ARX_OP_TX_HI_WR, `ARX_OP_TX_LO_WR: begin
                                    state_r <= arx_pkg::ARX_ST_WRITE;
                                    len_r   <= `ARX_LEN_TX;
                                end
                                `ARX_OP_LABEL_RD, `ARX_OP_FIFO_RD, `ARX_OP_CFG_RD, `ARX_OP_STATUS_RD: begin
                                    state_r <= arx_pkg::ARX_ST_READ;
                                end
                                default: begin
                                    state_r <= arx_pkg::ARX_ST_SKIP;
                                end
                            endcase
                        end
                    end
                    arx_pkg::ARX_ST_WRITE: begin
                        if (sck_rise) begin
                            shreg_r <= wr_data;
                            cnt_r   <= cnt_r + 8'h01;
                        end
                        if (commit) begin
                            state_r <= arx_pkg::ARX_ST_SKIP;
                        end
                    end
                    arx_pkg::ARX_ST_READ: begin
                        if (sck_fall) begin
                            so_r    <= shreg_r[127];
                            shreg_r <= {shreg_r[126:0], 1'b0};
                        end
                    end
                    arx_pkg::ARX_ST_SKIP: begin
                        so_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign so = so_r;

    // Field commit into the addressed store; a bad channel nibble makes a label or config write vanish, transmit writes ignore it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int c = 0; c < `ARX_CHANNELS; c++) begin
                cfg_r[c]   <= `ARX_CFG_RESET;
                label_r[c] <= '0;
            end
            tx_word      <= 32'h0000_0000;
            tx_low_speed <= 1'b0;
            tx_load      <= 1'b0;
        end else if (ce) begin
            tx_load <= 1'b0;
            if (commit) begin
                unique case (tgt_op_r)
                    `ARX_OP_LABEL_WR: begin
                        if (tgt_ok_r) begin
                            label_r[tgt_ch_r] <= wr_data;
                        end
                    end
                    `ARX_OP_CFG_WR: begin
                        if (tgt_ok_r) begin
                            cfg_r[tgt_ch_r] <= wr_data[15:0] & `ARX_CFG_USED_MASK;
                        end
                    end
                    `ARX_OP_TX_HI_WR, `ARX_OP_TX_LO_WR: begin
                        tx_word      <= wr_data[31:0];
                        tx_low_speed <= (tgt_op_r == `ARX_OP_TX_LO_WR);
                        tx_load      <= 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Incoming words wait here; draining stalls on a read pop so a same-cycle push cannot override the pop in the channel store
    arx_fifo #(
        .W     (`ARX_ING_WIDTH),
        .DEPTH (`ARX_ING_DEPTH)
    ) u_ingress (
        .clk       (clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .in_data   ({rx_chan, rx_word}),
        .out_valid (ing_valid),
        .out_ready (ing_ready),
        .out_data  (ing_data)
    );

    assign ing_ready = ~pop_strobe;
    assign ing_ch    = ing_data[34:32];
    assign ing_word  = ing_data[31:0];

    // Acceptance filter: channel enabled, label table and decoder bits
    always_comb begin
        ing_accept = ce & ing_valid & ing_ready & ~cfg_r[ing_ch][`ARX_CFG_CH_RST];
        if (cfg_r[ing_ch][`ARX_CFG_LABEL_EN] && !arx_label_hit(label_r[ing_ch], ing_word[7:0])) begin
            ing_accept = 1'b0;
        end
        if (cfg_r[ing_ch][`ARX_CFG_DEC_EN] &&
            ((ing_word[9] != cfg_r[ing_ch][`ARX_CFG_BIT10_VAL]) ||
             (ing_word[8] != cfg_r[ing_ch][`ARX_CFG_BIT9_VAL]))) begin
            ing_accept = 1'b0;
        end
        ing_store = ing_word;
        if (cfg_r[ing_ch][`ARX_CFG_PARITY_EN]) begin
            ing_store[31] = ~(^ing_word);
        end
    end

    // One receive store per channel, overwriting the newest word when full
    for (genvar i = 0; i < `ARX_CHANNELS; i++) begin : g_chan
        logic [31:0] slot_r [`ARX_RX_DEPTH];
        logic [1:0]  wr_ptr_r;
        logic [1:0]  rd_ptr_r;
        logic [2:0]  count_r;
        logic        clr;
        logic        push;
        logic        pop;
        logic        full;

        assign cfg_wr[i] = commit && (tgt_op_r == `ARX_OP_CFG_WR) && tgt_ok_r && (tgt_ch_r == 3'(i));
        assign clr  = master_clr | cfg_wr[i] | cfg_r[i][`ARX_CFG_CH_RST];
        assign push = ing_accept && (ing_ch == 3'(i));
        assign pop  = pop_strobe && (dec_ch == 3'(i)) && (count_r != 3'h0);
        assign full = (count_r == `ARX_RX_FULL_CNT);

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                wr_ptr_r <= 2'h0;
                rd_ptr_r <= 2'h0;
                count_r  <= 3'h0;
                for (int k = 0; k < `ARX_RX_DEPTH; k++) begin
                    slot_r[k] <= 32'h0000_0000;
                end
            end else if (ce) begin
                if (clr) begin
                    wr_ptr_r <= 2'h0;
                    rd_ptr_r <= 2'h0;
                    count_r  <= 3'h0;
                end else if (push && full) begin
                    slot_r[wr_ptr_r - 2'h1] <= ing_store;
                end else if (push) begin
                    slot_r[wr_ptr_r] <= ing_store;
                    wr_ptr_r         <= wr_ptr_r + 2'h1;
                    count_r          <= count_r + 3'h1;
                end else if (pop) begin
                    rd_ptr_r <= rd_ptr_r + 2'h1;
                    count_r  <= count_r - 3'h1;
                end
            end
        end

        assign head_word[i]             = slot_r[rd_ptr_r];
        assign fifo_empty[i]            = (count_r == 3'h0);
        assign fifo_full[i]             = full;
        assign per_channel_indicator[i] = cfg_r[i][`ARX_CFG_IND_MODE] ? full : (count_r != 3'h0);
        assign rate_select_bit[i]       = cfg_r[i][`ARX_CFG_RATE];
        assign loopback_select[i]       = cfg_r[i][`ARX_CFG_LOOPBACK];
        assign receiver_clear[i]        = clr;
    end

    // Status summary and combined indicator
    assign status        = {fifo_full, fifo_empty};
    assign indicator_any = |per_channel_indicator;
endmodule : arx_cmd_port

// [hw/arx_consts.svh]
`ifndef ARX_CONSTS_SVH
`define ARX_CONSTS_SVH

// Instruction fields
`define ARX_INSTR_BITS      8'h08
`define ARX_OP_NOP          4'h0
`define ARX_OP_LABEL_WR     4'h1
`define ARX_OP_LABEL_RD     4'h2
`define ARX_OP_FIFO_RD      4'h3
`define ARX_OP_CFG_WR       4'h4
`define ARX_OP_CFG_RD       4'h5
`define ARX_OP_STATUS_RD    4'h6
`define ARX_OP_MASTER_RST   4'h7
`define ARX_OP_TX_HI_WR     4'h8
`define ARX_OP_TX_LO_WR     4'h9
`define ARX_CHAN_FIRST      4'h1
`define ARX_CHAN_LAST       4'h8

// Data field lengths in bits
`define ARX_LEN_CFG         8'h10
`define ARX_LEN_TX          8'h20
`define ARX_LEN_LABEL       8'h80

// Channel configuration bit positions
`define ARX_CFG_RATE        0
`define ARX_CFG_IND_MODE    1
`define ARX_CFG_LABEL_EN    2
`define ARX_CFG_CH_RST      3
`define ARX_CFG_PARITY_EN   4
`define ARX_CFG_LOOPBACK    5
`define ARX_CFG_DEC_EN      6
`define ARX_CFG_BIT10_VAL   7
`define ARX_CFG_BIT9_VAL    8
`define ARX_CFG_LBL_ORDER   9
`define ARX_CFG_USED_MASK   16'h03FF
`define ARX_CFG_RESET       16'h0000

// Storage sizes
`define ARX_CHANNELS        8
`define ARX_RX_DEPTH        4
`define ARX_RX_FULL_CNT     3'h4
`define ARX_ING_DEPTH       16
`define ARX_ING_WIDTH       35

`endif

// [hw/arx_pkg.sv]
package arx_pkg;

    // Serial sequencer phase
    typedef enum logic [1:0] {
        ARX_ST_INSTR = 2'b00,
        ARX_ST_WRITE = 2'b01,
        ARX_ST_READ  = 2'b10,
        ARX_ST_SKIP  = 2'b11
    } arx_state_t;

endpackage : arx_pkg

// [hw/arx_fifo.sv]
`timescale 1ns/1ps
module arx_fifo #(
    parameter int W     = 35,
    parameter int DEPTH = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  slot_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0]   count_r;
    logic          push;
    logic          pop;

    // Full and empty come straight from the occupancy count
    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data  = slot_r[rd_ptr_r];
    assign push      = ce & in_valid & in_ready;
    assign pop       = ce & out_valid & out_ready;

    // Storage write; no reset needed on the data itself
    always_ff @(posedge clk) begin
        if (push) begin
            slot_r[wr_ptr_r] <= in_data;
        end
    end

    // Pointers wrap naturally since DEPTH is a power of two
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule : arx_fifo

// [verification/arx_cmd_port_props.sv]
`timescale 1ns/1ps
module arx_cmd_port_props (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        cs_n,
    input wire logic        sck,
    input wire logic        so,
    input wire logic        hardware_reset_pin,
    input wire logic        rx_valid,
    input wire logic        rx_ready,
    input wire logic [7:0]  per_channel_indicator,
    input wire logic        indicator_any,
    input wire logic [7:0]  rate_select_bit,
    input wire logic [7:0]  loopback_select,
    input wire logic [31:0] tx_word,
    input wire logic        tx_low_speed,
    input wire logic        tx_load
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Two samples of the pin so the first clear edge has landed
    sequence s_hw_hold;
        hardware_reset_pin [*2];
    endsequence
    // Ingress drains one per clock, so a short quiet spell frees a slot
    sequence s_quiet;
        !rx_valid [*3];
    endsequence
    AST_SO_IDLE: assert property (cs_n |=> !so)
        else $error("so not low after deselect");
    AST_SO_CAUSE: assert property ($changed(so) |-> $past(cs_n) || ($past(sck, 2) && !$past(sck)))
        else $error("so moved without a clock fall");
    AST_IND_ANY: assert property (indicator_any == |per_channel_indicator)
        else $error("combined indicator wrong");
    AST_HW_CLEAR: assert property (s_hw_hold |-> per_channel_indicator == 8'h00)
        else $error("indicator set during hardware reset");
    AST_TX_PULSE: assert property (tx_load |=> !tx_load)
        else $error("transmit load longer than one cycle");
    AST_TX_CAUSE: assert property ($changed(tx_word) || $changed(tx_low_speed) |-> ##[0:1] tx_load)
        else $error("transmit word changed without load");
    AST_CFG_FRAMED: assert property ($changed(rate_select_bit) || $changed(loopback_select) |-> !$past(cs_n))
        else $error("configuration changed outside a frame");
    AST_RDY_DRAIN: assert property (s_quiet |-> rx_ready)
        else $error("ingress not draining");
endmodule : arx_cmd_port_props

bind arx_cmd_port arx_cmd_port_props arx_cmd_port_props_inst (
    .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .so(so), .hardware_reset_pin(hardware_reset_pin),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .per_channel_indicator(per_channel_indicator),
    .indicator_any(indicator_any), .rate_select_bit(rate_select_bit), .loopback_select(loopback_select),
    .tx_word(tx_word), .tx_low_speed(tx_low_speed), .tx_load(tx_load)
);

// [verification/arx_spi_host.sv]
`timescale 1ns/1ps
module arx_spi_host (
    input wire logic clk,
    input wire logic so,
    output logic     cs_n,
    output logic     sck,
    output logic     si
);
    // Idle bus: deselected, clock parked low
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // One frame; each clock phase spans two system clocks so every edge is seen
    task automatic xfer(input logic [7:0] ins, input logic [127:0] wd, input int n, output logic [127:0] rd);
        logic [135:0] sh;
        sh = {ins, wd};
        rd = '0;
        @(negedge clk);
        cs_n = 1'b0;
        for (int i = 0; i < 8 + n; i++) begin
            @(negedge clk);
            sck = 1'b0;
            si = sh[135 - i];
            @(negedge clk);
            if (i >= 8) rd = {rd[126:0], so};
            @(negedge clk);
            sck = 1'b1;
            @(negedge clk);
        end
        sck = 1'b0;
        @(negedge clk);
        cs_n = 1'b1;
        si = ~si; // Released line must not look like held data
        @(negedge clk);
    endtask : xfer
endmodule : arx_spi_host

// [verification/arinc_rx_spi_command_port_tb.sv]
`timescale 1ns/1ps
module arinc_rx_spi_command_port_tb;
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         hardware_reset_pin = 1'b0;
    logic         rx_valid = 1'b0;
    logic [2:0]   rx_chan = 3'h0;
    logic [31:0]  rx_word = 32'h0;
    logic         cs_n, sck, si, so, rx_ready, indicator_any, tx_low_speed, tx_load;
    logic [7:0]   per_channel_indicator, rate_select_bit, loopback_select, receiver_clear;
    logic         ce = 1'b1;
    logic [31:0]  tx_word;
    logic [127:0] rd, lbl;
    logic [31:0]  w [5];
    logic [15:0]  v;
    int           num_errors = 0;
    int           checks = 0;
    int           cyc = 0;
    int           seed = 32'h0053;

    always #50 clk = ~clk;

    arx_spi_host arx_spi_host_inst (.clk(clk), .so(so), .cs_n(cs_n), .sck(sck), .si(si));
    arx_cmd_port arx_cmd_port_inst (
        .clk(clk), .rst_n(rst_n), .ce(ce), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
        .hardware_reset_pin(hardware_reset_pin), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_chan(rx_chan), .rx_word(rx_word), .per_channel_indicator(per_channel_indicator),
        .indicator_any(indicator_any), .rate_select_bit(rate_select_bit), .loopback_select(loopback_select),
        .receiver_clear(receiver_clear), .tx_word(tx_word), .tx_low_speed(tx_low_speed), .tx_load(tx_load));

    // Compare tasks: one for serial reads, one for pins
    task automatic rd_chk(input logic [7:0] ins, input int n, input logic [127:0] exp);
        arx_spi_host_inst.xfer(ins, 128'h0, n, rd);
        checks++;
        if (rd !== exp) begin
            num_errors++;
            $display("unexpected read %h: expected %h, seen %h", ins, exp, rd);
        end
    endtask : rd_chk
    task automatic chk_pin(input string what, input logic [127:0] exp, input logic [127:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk_pin
    // Write data is left-aligned so its MSB follows the instruction
    task automatic wr(input logic [7:0] ins, input logic [127:0] d, input int n);
        arx_spi_host_inst.xfer(ins, d << (128 - n), n, rd);
    endtask : wr
    task automatic push(input logic [2:0] ch, input logic [31:0] wd);
        @(negedge clk);
        rx_valid = 1'b1;
        rx_chan = ch;
        rx_word = wd;
        @(negedge clk);
        rx_valid = 1'b0;
        rx_word = $random(seed);
        repeat (3) @(negedge clk);
    endtask : push
    // Label byte is bit-reversed unless the order bit keeps it as received
    function automatic logic [31:0] exp_rx(input logic [31:0] wd, input logic keep);
        return keep ? wd : {wd[31:8], wd[0], wd[1], wd[2], wd[3], wd[4], wd[5], wd[6], wd[7]};
    endfunction : exp_rx
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            close_out();
        end
    end

    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        rd_chk(8'h06, 16, 128'h00FF);
        chk_pin("tx_word", 128'h0, tx_word);
        // Descending, so v ends up holding channel 1's setting for the no-op check
        for (int c = 8; c >= 1; c--) begin
            v = $random(seed);
            wr({c[3:0], 4'h4}, v, 16);
            rd_chk({c[3:0], 4'h5}, 16, v & 16'h03FF);
            chk_pin("rate", v[0], rate_select_bit[c - 1]);
            chk_pin("loopback", v[5], loopback_select[c - 1]);
            chk_pin("clear", v[3], receiver_clear[c - 1]);
        end
        rd_chk(8'h05, 16, 128'h0);
        for (int op = 9; op <= 15; op++) wr({4'h1, op == 9 ? 4'h0 : op[3:0]}, 16'hFFFF, 16);
        rd_chk(8'h15, 16, v & 16'h03FF);
        $display("test config done");
        lbl = {$random(seed), $random(seed), $random(seed), $random(seed)};
        wr(8'h31, lbl, 128);
        rd_chk(8'h32, 128, lbl);
        wr(8'h14, 16'h0222, 16);
        foreach (w[i]) w[i] = $random(seed);
        push(3'h0, w[0]);
        chk_pin("indicator", 1'b0, per_channel_indicator[0]);
        rd_chk(8'h06, 16, 128'h00FE);
        for (int i = 1; i < 5; i++) push(3'h0, w[i]);
        chk_pin("indicator", 2'b11, {indicator_any, per_channel_indicator[0]});
        rd_chk(8'h06, 16, 128'h01FE);
        for (int i = 0; i < 5; i++) rd_chk(8'h13, 32, i == 4 ? 32'h0 : i == 3 ? w[4] : w[i]);
        rd_chk(8'h06, 16, 128'h00FF);
        wr(8'h14, 16'h0020, 16);
        push(3'h0, w[1]);
        chk_pin("indicator", 1'b1, per_channel_indicator[0]);
        rd_chk(8'h13, 32, exp_rx(w[1], 1'b0));
        $display("test fifo done");
        push(3'h0, w[2]);
        wr(8'h14, 16'h0020, 16);
        rd_chk(8'h06, 16, 128'h00FF);
        push(3'h0, w[2]);
        wr(8'h57, 128'h0, 0);
        rd_chk(8'h06, 16, 128'h00FF);
        push(3'h0, w[3]);
        hardware_reset_pin = 1'b1;
        repeat (2) @(negedge clk);
        hardware_reset_pin = 1'b0;
        rd_chk(8'h06, 16, 128'h00FF);
        rd_chk(8'h15, 16, 128'h0020);
        $display("test clears done");
        wr(8'h24, 16'h00E0, 16);
        push(3'h1, {w[0][31:10], 2'b00, w[0][7:0]});
        push(3'h1, {w[1][31:10], 2'b10, w[1][7:0]});
        rd_chk(8'h23, 32, exp_rx({w[1][31:10], 2'b10, w[1][7:0]}, 1'b0));
        rd_chk(8'h23, 32, 128'h0);
        for (int s = 0; s < 2; s++) begin
            lbl[31:0] = $random(seed);
            wr({4'h0, 4'h8 + s[3:0]}, lbl[31:0], 32);
            chk_pin("tx_word", lbl[31:0], tx_word);
            chk_pin("tx_speed", s[0], tx_low_speed);
        end
        wr(8'h14, 16'h0001, 10);
        rd_chk(8'h15, 16, 128'h0020);
        // Clock enable low freezes everything, so an offered word is never taken
        ce = 1'b0;
        push(3'h0, w[0]);
        ce = 1'b1;
        rd_chk(8'h06, 16, 128'h00FF);
        $display("test decoder transmit abort done");
        close_out();
    end
endmodule : arinc_rx_spi_command_port_tb
